// ===== tct_map.svh
// Constants and functional notes for the thermal clock throttle
// Functional notes
// - Thermal control circuit turns on at a fixed maximum die temperature, not configurable.
// - While throttling, snoops continue and interrupts latch, serviced only in clock-on time.
// - Throttling stops and restarts the core clock repeatedly while active.
// - Automatic and on-demand modes exist; automatic wins when hot and both enabled.
// - Automatic mode throttles only when die reaches maximum operating temperature or processor-hot is driven low externally.
// - Automatic mode uses a fixed half-on half-off duty cycle.
// - Modulation period is in core cycles, so it shortens as core frequency rises.
// - Throttling ends when temperature falls, with hysteresis around the trip point.
// - On-demand enable bit 4 starts throttling at once regardless of temperature.
// - On-demand duty field bits 3:1 selects one to seven eighths clock-on.
// - Processor-hot output asserts from the trip point until the hysteresis release, even after temperature falls below the trip point.
// - Optional interrupt on assertion and/or deassertion of processor-hot.
// - Catastrophic overheat asserts thermal shutdown regardless of throttle modes.
// - Thermal shutdown is independent of core activity and makes no bus cycle.
// - Processor-hot pin is bidirectional; external drive activates throttling.
`ifndef TCT_MAP_SVH
`define TCT_MAP_SVH
`define TCT_CTRL_ODM_EN_BIT 4
`define TCT_CTRL_DUTY_HI 3
`define TCT_CTRL_DUTY_LO 1
`define TCT_AUTO_DUTY 3'h4
`define TCT_SLOT_CYCLES 16
`define TCT_SLOTS 8
`define TCT_HYST_CYCLES 32
`endif

// ===== tct_pkg.sv
// Types shared by the thermal clock throttle
package tct_pkg;
	typedef enum logic [1:0]
	{
		TCT_IDLE = 2'b00,
		TCT_ODM = 2'b01,
		TCT_AUTO = 2'b11
	} tct_mode_e;
	typedef logic [2:0] tct_duty_t;
endpackage

// ===== tct_slot_timer.sv
// Eight-slot modulation period timer
`timescale 1ns/10ps
`include "tct_map.svh"
module tct_slot_timer
#(
	parameter int SLOT_CYCLES = `TCT_SLOT_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic [2:0] slot
);
	localparam int CW = $clog2(SLOT_CYCLES) + 1;
	logic [CW-1:0] cnt_q;

	initial
	begin
		if (SLOT_CYCLES < 1)
			$error("SLOT_CYCLES must be at least one");
	end

	// Period counts core cycles, so it scales with core frequency
	always_ff @(posedge clk)
	begin
		if (rst || !run)
		begin
			cnt_q <= '0;
			slot <= 3'h0;
		end
		else if (cnt_q == CW'(SLOT_CYCLES - 1))
		begin
			cnt_q <= '0;
			slot <= slot + 3'h1;
		end
		else
			cnt_q <= cnt_q + CW'(1);
	end
endmodule

// ===== tct_thermal_clock_throttle.sv
// Thermal control circuit: throttling, processor-hot, thermal shutdown
`timescale 1ns/10ps
`include "tct_map.svh"
module tct_thermal_clock_throttle
#(
	parameter int SLOT_CYCLES = `TCT_SLOT_CYCLES,
	parameter int HYST_CYCLES = `TCT_HYST_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic temp_at_max,
	input wire logic temp_below_hyst,
	input wire logic temp_catastrophic,
	input wire logic automatic_throttle_mode,
	input wire logic [4:0] ctrl_reg,
	input wire logic int_on_assert_en,
	input wire logic int_on_deassert_en,
	input wire logic processor_hot_n_in,
	input wire logic irq_pending,
	output logic processor_hot_n_out,
	output logic processor_hot_n_oe,
	output logic thermal_shutdown_n,
	output logic core_clk_en,
	output logic irq_service_ok,
	output logic thermal_irq,
	output tct_pkg::tct_mode_e mode
);
	import tct_pkg::*;

	logic hot_q;
	logic ext_hot_q;
	logic thermal_control_circuit;
	logic on_slot;
	logic gate_pos_q;
	logic [2:0] slot;
	logic [$clog2(HYST_CYCLES+1):0] hyst_q;
	logic hot_prev_q;
	tct_duty_t duty;

	initial
	begin
		if (HYST_CYCLES < 1)
			$error("HYST_CYCLES must be at least one");
	end

	// ---------------------------------------------------------------
	// Temperature trip with hysteresis
	// ---------------------------------------------------------------
	// Trip level is the fixed sensor input; nothing here can move it
	// Release needs a sustained cool reading to stop rapid toggling
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hot_q <= 1'b0;
			hyst_q <= '0;
		end
		else if (temp_at_max)
		begin
			hot_q <= 1'b1;
			hyst_q <= '0;
		end
		else if (hot_q && temp_below_hyst)
		begin
			if (hyst_q == ($bits(hyst_q))'(HYST_CYCLES - 1))
				hot_q <= 1'b0;
			hyst_q <= hyst_q + 1'b1;
		end
		else
			hyst_q <= '0;
	end

	// External agent pulling processor-hot low requests throttling
	always_ff @(posedge clk)
	begin
		if (rst)
			ext_hot_q <= 1'b0;
		else
			ext_hot_q <= !processor_hot_n_in && !processor_hot_n_oe;
	end

	// ---------------------------------------------------------------
	// Mode and duty selection
	// ---------------------------------------------------------------
	// Automatic wins over on-demand when hot
	always_comb
	begin
		if (automatic_throttle_mode && (hot_q || ext_hot_q))
		begin
			thermal_control_circuit = 1'b1;
			duty = `TCT_AUTO_DUTY;
		end
		else if (ctrl_reg[`TCT_CTRL_ODM_EN_BIT])
		begin
			thermal_control_circuit = 1'b1;
			duty = ctrl_reg[`TCT_CTRL_DUTY_HI:`TCT_CTRL_DUTY_LO];
		end
		else
		begin
			thermal_control_circuit = 1'b0;
			duty = 3'h0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			mode <= TCT_IDLE;
		else if (automatic_throttle_mode && (hot_q || ext_hot_q))
			mode <= TCT_AUTO;
		else if (ctrl_reg[`TCT_CTRL_ODM_EN_BIT])
			mode <= TCT_ODM;
		else
			mode <= TCT_IDLE;
	end

	tct_slot_timer #(
		.SLOT_CYCLES(SLOT_CYCLES)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.run(thermal_control_circuit),
		.slot(slot)
	);

	// ---------------------------------------------------------------
	// Clock gating
	// ---------------------------------------------------------------
	// Duty of zero is treated as a reserved value and runs half on
	assign on_slot = !thermal_control_circuit ||
		(slot < ((duty == 3'h0) ? `TCT_AUTO_DUTY : duty));

	// Enable changes only on a rising edge, then is retimed to clock-low
	always_ff @(posedge clk)
	begin
		if (rst)
			gate_pos_q <= 1'b1;
		else
			// Shutdown is sticky, so the clock stays stopped once it has tripped
			gate_pos_q <= on_slot && !temp_catastrophic && thermal_shutdown_n;
	end

	always_ff @(negedge clk)
	begin
		if (rst)
			core_clk_en <= 1'b1;
		else
			core_clk_en <= gate_pos_q;
	end

	// Interrupts stay latched by the core; service only while clock runs
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_service_ok <= 1'b0;
		else
			irq_service_ok <= irq_pending && gate_pos_q;
	end

	// ---------------------------------------------------------------
	// Processor-hot pin and interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			processor_hot_n_out <= 1'b1;
			processor_hot_n_oe <= 1'b0;
		end
		else
		begin
			processor_hot_n_out <= 1'b0;
			processor_hot_n_oe <= hot_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hot_prev_q <= 1'b0;
			thermal_irq <= 1'b0;
		end
		else
		begin
			hot_prev_q <= hot_q;
			thermal_irq <= (hot_q && !hot_prev_q && int_on_assert_en) ||
				(!hot_q && hot_prev_q && int_on_deassert_en);
		end
	end

	// ---------------------------------------------------------------
	// Catastrophic shutdown
	// ---------------------------------------------------------------
	// Sticky until reset; no dependency on modes or core activity
	always_ff @(posedge clk)
	begin
		if (rst)
			thermal_shutdown_n <= 1'b1;
		else if (temp_catastrophic)
			thermal_shutdown_n <= 1'b0;
	end
endmodule

// ===== tct_throttle_props.sv
// Port assertions for the thermal clock throttle
`timescale 1ns/10ps
module tct_throttle_props
(
	input wire logic clk,
	input wire logic rst,
	input wire logic temp_at_max,
	input wire logic temp_catastrophic,
	input wire logic int_on_assert_en,
	input wire logic irq_pending,
	input wire logic processor_hot_n_out,
	input wire logic processor_hot_n_oe,
	input wire logic thermal_shutdown_n,
	input wire logic core_clk_en,
	input wire logic irq_service_ok,
	input wire logic thermal_irq,
	input wire tct_pkg::tct_mode_e mode
);
	import tct_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence trip_s;
		temp_catastrophic ##1 !thermal_shutdown_n;
	endsequence
	trip_fast_a: assert property (temp_catastrophic |-> trip_s) else $error("late trip");
	trip_hold_a: assert property (!thermal_shutdown_n |=> !thermal_shutdown_n) else $error("trip lost");
	trip_clock_a: assert property (!thermal_shutdown_n [*2] |-> !core_clk_en) else $error("clk on");
	hot_raise_a: assert property (temp_at_max |-> ##2 processor_hot_n_oe) else $error("no hot");
	hot_level_a: assert property (processor_hot_n_oe |-> !processor_hot_n_out) else $error("hot hi");
	irq_assert_a: assert property ($rose(processor_hot_n_oe) && int_on_assert_en
		|-> thermal_irq) else $error("no irq");
	irq_latch_a: assert property (irq_service_ok |-> $past(irq_pending)) else $error("bad irq ok");
	idle_run_a: assert property ((mode == TCT_IDLE && thermal_shutdown_n) [*3]
		|-> core_clk_en) else $error("idle gated");
endmodule
bind tct_thermal_clock_throttle tct_throttle_props chk (.clk, .rst, .temp_at_max,
	.temp_catastrophic, .int_on_assert_en, .irq_pending, .processor_hot_n_out,
	.processor_hot_n_oe, .thermal_shutdown_n, .core_clk_en, .irq_service_ok,
	.thermal_irq, .mode);

// ===== tct_platform.sv
// Platform side: hot line pull-up, firmware setup, core supply
`timescale 1ns/10ps
module tct_platform
(
	input wire logic ext_hot,
	input wire logic hot_oe,
	input wire logic shutdown_n,
	output logic hot_pin_n,
	output logic auto_mode,
	output logic vcore_on
);
	// Pulled-up line, low while either party pulls it
	assign hot_pin_n = !(hot_oe || ext_hot);
	assign auto_mode = 1'b1;
	assign vcore_on = shutdown_n;
endmodule

// ===== thermal_clock_throttle_tb.sv
// Self-checking bench for the thermal clock throttle
`timescale 1ns/10ps
module thermal_clock_throttle_tb;
	import tct_pkg::*;
	localparam int SC = 2;
	localparam int PER = 8 * SC;
	logic clk, rst, temp_at_max, temp_below_hyst, temp_catastrophic, int_a, int_d;
	logic ext_hot, irq_pending, auto_mode, pin_n, oe, out, sd_n, cke, iso, tirq, vcore;
	logic [4:0] ctrl_reg;
	tct_mode_e mode;
	int mismatches = 0, n_tests = 0, n_irq = 0, k;
	int duties[$] = '{1, 2, 3, 4, 5, 6, 7, 0};
	logic [31:0] seed = 32'h0000_6803;
	tct_thermal_clock_throttle #(.SLOT_CYCLES(SC), .HYST_CYCLES(4)) uut (.clk, .rst,
		.temp_at_max, .temp_below_hyst, .temp_catastrophic,
		.automatic_throttle_mode(auto_mode), .ctrl_reg, .int_on_assert_en(int_a),
		.int_on_deassert_en(int_d), .processor_hot_n_in(pin_n), .irq_pending,
		.processor_hot_n_out(out), .processor_hot_n_oe(oe), .thermal_shutdown_n(sd_n),
		.core_clk_en(cke), .irq_service_ok(iso), .thermal_irq(tirq), .mode);
	tct_platform plat (.ext_hot, .hot_oe(oe), .shutdown_n(sd_n), .hot_pin_n(pin_n),
		.auto_mode, .vcore_on(vcore));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	// Expected clock-on cycles in one period
	function automatic int exp_on(input int hot, input int d);
		return hot ? PER / 2 : (d == 0 ? 4 : d) * SC;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Settle, then count running cycles over one whole period
	task automatic on_count(output int n);
		repeat (20) @(posedge clk);
		n = 0;
		repeat (PER) @(posedge clk) n += (cke === 1'b1);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		seed <= xs(seed);
		irq_pending <= seed[0];
		if (tirq === 1'b1)
			n_irq++;
	end
	initial
	begin
		#100000;
		mismatches++;
		wrap_up();
	end
	initial
	begin
		rst = 1;
		ctrl_reg = '0;
		{temp_at_max, temp_below_hyst, temp_catastrophic, int_a, int_d, ext_hot} = '0;
		repeat (12) @(posedge clk);
		rst <= 0;
		foreach (duties[i])
		begin
			ctrl_reg <= {1'b1, duties[i][2:0], seed[1]};
			on_count(k);
			chk(k, exp_on(0, duties[i]));
			chk(mode, TCT_ODM);
		end
		$display("test duty sweep done");
		int_a <= 1;
		ctrl_reg <= 5'h13;
		temp_at_max <= 1;
		on_count(k);
		chk(k, exp_on(1, 1));
		chk(mode, TCT_AUTO);
		chk(pin_n, 0);
		chk(out, 0);
		chk(n_irq, 1);
		temp_at_max <= 0;
		repeat (10) @(posedge clk);
		chk(oe, 1);
		int_d <= 1;
		ctrl_reg <= '0;
		temp_below_hyst <= 1;
		on_count(k);
		chk(k, PER);
		chk(mode, TCT_IDLE);
		chk(n_irq, 2);
		$display("test auto and hysteresis done");
		ext_hot <= 1;
		on_count(k);
		chk(k, exp_on(1, 0));
		ext_hot <= 0;
		temp_catastrophic <= 1;
		on_count(k);
		chk(k, 0);
		chk(vcore, 0);
		chk(iso, 0);
		temp_catastrophic <= 0;
		repeat (3) @(posedge clk);
		chk(sd_n, 0);
		$display("test external hot and trip done");
		wrap_up();
	end
endmodule
